// ==== rtl/cgd_top.sv ====
// Compressor protection, power-up hold-off and defrost sequencing with an AXI4-Lite slave.
//
// The address map and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module cgd_top #(
	parameter int TICK_CYCLES = cgd_pkg::TICK_CYC
) (
	input wire logic I_CLK,
	input wire logic I_NRST,
	input wire logic [7:0] I_AXI_AWADDR,
	input wire logic I_AXI_AWVALID,
	output logic O_AXI_AWREADY,
	input wire logic [31:0] I_AXI_WDATA,
	input wire logic [3:0] I_AXI_WSTRB,
	input wire logic I_AXI_WVALID,
	output logic O_AXI_WREADY,
	output logic [1:0] O_AXI_BRESP,
	output logic O_AXI_BVALID,
	input wire logic I_AXI_BREADY,
	input wire logic [7:0] I_AXI_ARADDR,
	input wire logic I_AXI_ARVALID,
	output logic O_AXI_ARREADY,
	output logic [31:0] O_AXI_RDATA,
	output logic [1:0] O_AXI_RRESP,
	output logic O_AXI_RVALID,
	input wire logic I_AXI_RREADY,
	input wire logic I_COOL_REQ,
	input wire logic signed [15:0] I_EVAP_TEMP,
	input wire logic I_EVAP_OK,
	input wire logic I_DEFROST_END,
	input wire logic [2:0] I_RTC_DAY,
	input wire logic [10:0] I_RTC_MIN,
	output logic O_COMP,
	output logic O_DEFROST,
	output logic O_AUX,
	output logic O_PROP_DEFPWR,
	output logic O_LAMP,
	output logic O_HOLDOFF_IND,
	output logic O_DEFROST_ACT
);

	localparam int TW = $clog2(TICK_CYCLES);
	localparam int CTRL_W_L = cgd_pkg::CTRL_W;

	logic rst_s1_ff;
	logic rst_n;
	logic [TW-1:0] tick_cnt_ff;
	logic tick_ff;
	logic [5:0] sec_cnt_ff;
	logic min_tick_ff;
	logic blink_ff;
	logic [CTRL_W_L-1:0] ctrl_ff;
	logic [15:0] tp_ff [4];
	logic [15:0] di_ff;
	logic [15:0] sd_ff;
	logic signed [15:0] tend_ff;
	logic signed [15:0] tena_ff;
	logic [15:0] evt_ff [cgd_pkg::EVT_NUM];
	logic [7:0] aw_addr_ff;
	logic aw_hold_ff;
	logic awrdy_ff;
	logic [31:0] w_data_ff;
	logic [3:0] w_strb_ff;
	logic w_hold_ff;
	logic wrdy_ff;
	logic bvalid_ff;
	logic [1:0] bresp_ff;
	logic arrdy_ff;
	logic rvalid_ff;
	logic [31:0] rdata_ff;
	logic [1:0] rresp_ff;
	logic [31:0] rd_data;
	logic rd_ok;
	logic start_pend_ff;
	logic comp_ff;
	logic comp_d_ff;
	logic demand_ff;
	logic dfo_ff;
	logic aux_ff;
	logic prop_ff;
	logic lamp_ff;
	logic hind_ff;
	logic dfa_ff;
	logic therm_ff;
	logic first_ff;
	logic [15:0] elapsed_ff;
	logic [10:0] rtc_min_d_ff;
	logic [3:0] ld;
	logic [15:0] ld_val [4];
	logic [3:0] busy;
	logic [cgd_pkg::EVT_NUM-1:0] evt_hit;
	logic want;
	logic nxt_comp;
	logic nxt_dfo;
	logic nxt_aux;

	cgd_pkg::cgd_dtype_t dtype;
	cgd_pkg::cgd_dcnt_t dcnt;
	assign dtype = cgd_pkg::cgd_dtype_t'(ctrl_ff[cgd_pkg::CTRL_DT_MSB:cgd_pkg::CTRL_DT_LSB]);
	assign dcnt = cgd_pkg::cgd_dcnt_t'(ctrl_ff[cgd_pkg::CTRL_DC_MSB:cgd_pkg::CTRL_DC_LSB]);

	// Expands two byte strobes into a 16-bit field merge.
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] nw,
			input logic [1:0] strb);
		merge16 = {strb[1] ? nw[15:8] : old[15:8], strb[0] ? nw[7:0] : old[7:0]};
	endfunction

	// Decodes an address in the event page.
	function automatic logic is_evt(input logic [7:0] a);
		is_evt = (a[7:6] == cgd_pkg::EVT_PAGE) && (a[1:0] == 2'h0) &&
			(int'(a[5:2]) < cgd_pkg::EVT_NUM);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Reset release and time base.

	// Reset is asserted at once and released through two flip-flops.
	always_ff @(posedge I_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			rst_s1_ff <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_s1_ff <= 1'b1;
			rst_n <= rst_s1_ff;
		end
	end

	// One common second tick, a minute tick and the blink phase.
	always_ff @(posedge I_CLK or negedge rst_n) begin
		if (!rst_n) begin
			tick_cnt_ff <= '0;
			tick_ff <= 1'b0;
			sec_cnt_ff <= 6'h00;
			min_tick_ff <= 1'b0;
			blink_ff <= 1'b0;
		end else begin
			tick_ff <= (tick_cnt_ff == TW'(TICK_CYCLES - 1));
			tick_cnt_ff <= (tick_cnt_ff == TW'(TICK_CYCLES - 1)) ? '0 : tick_cnt_ff + TW'(1);
			min_tick_ff <= tick_ff && (sec_cnt_ff == cgd_pkg::SEC_PER_MIN - 6'h01);
			if (tick_ff) begin
				sec_cnt_ff <= (sec_cnt_ff == cgd_pkg::SEC_PER_MIN - 6'h01) ? 6'h00 :
					sec_cnt_ff + 6'h01;
				blink_ff <= !blink_ff;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite slave.

	logic aw_take;
	logic w_take;
	logic wr_go;
	logic ar_take;
	assign aw_take = I_AXI_AWVALID && awrdy_ff;
	assign w_take = I_AXI_WVALID && wrdy_ff;
	assign wr_go = aw_hold_ff && w_hold_ff && !bvalid_ff;
	assign ar_take = I_AXI_ARVALID && arrdy_ff;

	// Address and data are taken in either order; the response follows both.
	always_ff @(posedge I_CLK or negedge rst_n) begin
		if (!rst_n) begin
			aw_addr_ff <= 8'h00;
			aw_hold_ff <= 1'b0;
			awrdy_ff <= 1'b0;
			w_data_ff <= 32'h0000_0000;
			w_strb_ff <= 4'h0;
			w_hold_ff <= 1'b0;
			wrdy_ff <= 1'b0;
			bvalid_ff <= 1'b0;
			bresp_ff <= cgd_pkg::RESP_OKAY;
		end else begin
			if (aw_take) begin
				aw_addr_ff <= I_AXI_AWADDR;
			end
			if (w_take) begin
				w_data_ff <= I_AXI_WDATA;
				w_strb_ff <= I_AXI_WSTRB;
			end
			aw_hold_ff <= (aw_hold_ff && !wr_go) || aw_take;
			w_hold_ff <= (w_hold_ff && !wr_go) || w_take;
			awrdy_ff <= !((aw_hold_ff && !wr_go) || aw_take);
			wrdy_ff <= !((w_hold_ff && !wr_go) || w_take);
			if (wr_go) begin
				bvalid_ff <= 1'b1;
				bresp_ff <= (rd_map(aw_addr_ff) && (aw_addr_ff != cgd_pkg::ADDR_STAT)) ?
					cgd_pkg::RESP_OKAY : cgd_pkg::RESP_SLVERR;
			end else if (I_AXI_BREADY) begin
				bvalid_ff <= 1'b0;
			end
		end
	end

	// Tells whether an address holds a register.
	function automatic logic rd_map(input logic [7:0] a);
		rd_map = (a[7:6] == 2'h0 && a[1:0] == 2'h0 && a <= cgd_pkg::ADDR_STAT) || is_evt(a);
	endfunction

	// Register file; status and unmapped writes are ignored.
	always_ff @(posedge I_CLK or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_ff <= cgd_pkg::CTRL_RST;
			tp_ff[0] <= cgd_pkg::TIME_RST;
			tp_ff[1] <= cgd_pkg::TIME_RST;
			tp_ff[2] <= cgd_pkg::TIME_RST;
			tp_ff[3] <= cgd_pkg::POD_RST;
			di_ff <= cgd_pkg::DI_RST;
			sd_ff <= cgd_pkg::SD_RST;
			tend_ff <= cgd_pkg::TEND_RST;
			tena_ff <= cgd_pkg::TENA_RST;
			for (int i = 0; i < cgd_pkg::EVT_NUM; i++) begin
				evt_ff[i] <= 16'h0000;
			end
		end else if (wr_go) begin
			case (aw_addr_ff)
				cgd_pkg::ADDR_CTRL: begin
					if (w_strb_ff[0]) begin
						ctrl_ff <= w_data_ff[CTRL_W_L-1:0];
					end
				end
				cgd_pkg::ADDR_P1: tp_ff[0] <= merge16(tp_ff[0], w_data_ff[15:0], w_strb_ff[1:0]);
				cgd_pkg::ADDR_P2: tp_ff[1] <= merge16(tp_ff[1], w_data_ff[15:0], w_strb_ff[1:0]);
				cgd_pkg::ADDR_P3: tp_ff[2] <= merge16(tp_ff[2], w_data_ff[15:0], w_strb_ff[1:0]);
				cgd_pkg::ADDR_POD: tp_ff[3] <= merge16(tp_ff[3], w_data_ff[15:0], w_strb_ff[1:0]);
				cgd_pkg::ADDR_DI: di_ff <= merge16(di_ff, w_data_ff[15:0], w_strb_ff[1:0]);
				cgd_pkg::ADDR_SD: sd_ff <= merge16(sd_ff, w_data_ff[15:0], w_strb_ff[1:0]);
				cgd_pkg::ADDR_TEMP: begin
					tend_ff <= $signed(merge16(tend_ff, w_data_ff[15:0], w_strb_ff[1:0]));
					tena_ff <= $signed(merge16(tena_ff, w_data_ff[31:16], w_strb_ff[3:2]));
				end
				default: begin
					if (is_evt(aw_addr_ff)) begin
						evt_ff[aw_addr_ff[5:2]] <= merge16(evt_ff[aw_addr_ff[5:2]],
							w_data_ff[15:0], w_strb_ff[1:0]);
					end
				end
			endcase
		end
	end

	// Read multiplexer; status shows the live sequencer state.
	always_comb begin
		rd_data = 32'h0000_0000;
		rd_ok = 1'b1;
		case (I_AXI_ARADDR)
			cgd_pkg::ADDR_CTRL: rd_data = {26'h0, ctrl_ff};
			cgd_pkg::ADDR_P1: rd_data = {16'h0, tp_ff[0]};
			cgd_pkg::ADDR_P2: rd_data = {16'h0, tp_ff[1]};
			cgd_pkg::ADDR_P3: rd_data = {16'h0, tp_ff[2]};
			cgd_pkg::ADDR_POD: rd_data = {16'h0, tp_ff[3]};
			cgd_pkg::ADDR_DI: rd_data = {16'h0, di_ff};
			cgd_pkg::ADDR_SD: rd_data = {16'h0, sd_ff};
			cgd_pkg::ADDR_TEMP: rd_data = {tena_ff, tend_ff};
			cgd_pkg::ADDR_STAT: rd_data = {elapsed_ff, 9'h0, first_ff, start_pend_ff | busy[3],
				|busy[2:0], dfa_ff, aux_ff, dfo_ff, comp_ff};
			default: begin
				if (is_evt(I_AXI_ARADDR)) begin
					rd_data = {16'h0, evt_ff[I_AXI_ARADDR[5:2]]};
				end else begin
					rd_ok = 1'b0;
				end
			end
		endcase
	end

	// One read at a time; address ready drops until the data is taken.
	always_ff @(posedge I_CLK or negedge rst_n) begin
		if (!rst_n) begin
			arrdy_ff <= 1'b0;
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h0000_0000;
			rresp_ff <= cgd_pkg::RESP_OKAY;
		end else begin
			arrdy_ff <= !(ar_take || (rvalid_ff && !I_AXI_RREADY));
			if (ar_take) begin
				rvalid_ff <= 1'b1;
				rdata_ff <= rd_data;
				rresp_ff <= rd_ok ? cgd_pkg::RESP_OKAY : cgd_pkg::RESP_SLVERR;
			end else if (I_AXI_RREADY) begin
				rvalid_ff <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Protection timers and power-up hold-off.

	logic hg;
	logic holdoff_act;
	logic prot_busy;
	logic comp_rise;
	logic comp_fall;
	logic dfa_start;
	logic dfa_end;
	assign hg = (dtype == cgd_pkg::DT_HG);
	assign holdoff_act = start_pend_ff || busy[3];
	assign prot_busy = |busy[2:0];
	assign comp_rise = comp_ff && !comp_d_ff;
	assign comp_fall = !comp_ff && comp_d_ff;

	// Timer loads; hot-gas mode retimes the first two around the defrost.
	assign ld[0] = (want && !demand_ff) || (hg && dfa_end);
	assign ld[1] = (comp_fall && !hg) || (hg && dfa_start);
	assign ld[2] = comp_rise;
	assign ld[3] = start_pend_ff;

	for (genvar g = 0; g < 4; g++) begin : g_tmr
		assign ld_val[g] = tp_ff[g];
		cgd_countdown #(.W(16)) u_tmr (
			.i_clk(I_CLK),
			.i_rst_n(rst_n),
			.i_tick(tick_ff),
			.i_load(ld[g]),
			.i_value(ld_val[g]),
			.o_busy(busy[g])
		);
	end

	// Compressor demand per defrost mode.
	always_comb begin
		want = I_COOL_REQ;
		if (dfa_ff) begin
			case (dtype)
				cgd_pkg::DT_IN: want = 1'b1;
				cgd_pkg::DT_NO: want = I_COOL_REQ;
				default: want = 1'b0;
			endcase
		end
	end

	// Turn-on needs every timer expired; a running output is never cut by them.
	assign nxt_comp = want && demand_ff && (comp_ff || !prot_busy) && !holdoff_act;

	// Defrost output and suction valve per mode.
	always_comb begin
		nxt_dfo = 1'b0;
		nxt_aux = 1'b0;
		if (dfa_ff) begin
			case (dtype)
				cgd_pkg::DT_EL: nxt_dfo = ctrl_ff[cgd_pkg::CTRL_DFU];
				cgd_pkg::DT_ET: nxt_dfo = !I_EVAP_OK || therm_ff;
				cgd_pkg::DT_HG: begin
					nxt_dfo = !busy[1];
					nxt_aux = busy[1];
				end
				default: nxt_dfo = 1'b1;
			endcase
		end else begin
			nxt_aux = hg;
		end
	end

	// Output stage; all but the lamp and the blinking hold-off indication stay off during the hold-off.
	always_ff @(posedge I_CLK or negedge rst_n) begin
		if (!rst_n) begin
			start_pend_ff <= 1'b1;
			demand_ff <= 1'b0;
			comp_ff <= 1'b0;
			comp_d_ff <= 1'b0;
			dfo_ff <= 1'b0;
			aux_ff <= 1'b0;
			prop_ff <= 1'b0;
			lamp_ff <= 1'b0;
			hind_ff <= 1'b0;
		end else begin
			start_pend_ff <= 1'b0;
			demand_ff <= want;
			comp_ff <= nxt_comp;
			comp_d_ff <= comp_ff;
			dfo_ff <= nxt_dfo && !holdoff_act;
			aux_ff <= nxt_aux && !holdoff_act;
			prop_ff <= dfa_ff && (dtype == cgd_pkg::DT_IN) && !holdoff_act;
			lamp_ff <= (want && !comp_ff && prot_busy) ? blink_ff : comp_ff;
			hind_ff <= holdoff_act && blink_ff;
		end
	end

	// Evaporator heating thermostat with fixed hysteresis.
	always_ff @(posedge I_CLK or negedge rst_n) begin
		if (!rst_n) begin
			therm_ff <= 1'b0;
		end else if (I_EVAP_TEMP >= tend_ff) begin
			therm_ff <= 1'b0;
		end else if (I_EVAP_TEMP <= tend_ff - cgd_pkg::HYST) begin
			therm_ff <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Automatic defrost starts.

	logic count_en;
	logic iv_hit;
	logic cs_hit;
	logic cl_hit;
	logic start_ok;
	logic start;
	assign count_en = !dfa_ff && ((dcnt == cgd_pkg::DC_RT) || (dcnt == cgd_pkg::DC_CS) ||
		((dcnt == cgd_pkg::DC_CT) && comp_ff));
	assign iv_hit = (dcnt != cgd_pkg::DC_CL) && (di_ff != 16'h0000) &&
		(elapsed_ff >= (first_ff ? sd_ff : di_ff));
	assign cs_hit = (dcnt == cgd_pkg::DC_CS) && comp_fall;
	assign cl_hit = (dcnt == cgd_pkg::DC_CL) && (rtc_min_d_ff != I_RTC_MIN) && (|evt_hit);
	assign start_ok = !I_EVAP_OK || ((I_EVAP_TEMP <= tena_ff) && (I_EVAP_TEMP < tend_ff));
	assign start = (iv_hit || cs_hit || cl_hit) && start_ok && !dfa_ff && !holdoff_act;
	assign dfa_start = start;
	assign dfa_end = dfa_ff && I_DEFROST_END;

	// Each event fires once when the clock enters its minute on a selected day.
	for (genvar e = 0; e < cgd_pkg::EVT_NUM; e++) begin : g_evt
		assign evt_hit[e] = (evt_ff[e][10:0] == I_RTC_MIN) &&
			cgd_pkg::day_match(evt_ff[e][15:12], I_RTC_DAY);
	end

	// Defrost phase, first-defrost flag and interval minutes since the last defrost.
	always_ff @(posedge I_CLK or negedge rst_n) begin
		if (!rst_n) begin
			dfa_ff <= 1'b0;
			first_ff <= 1'b1;
			elapsed_ff <= 16'h0000;
			rtc_min_d_ff <= 11'h000;
		end else begin
			rtc_min_d_ff <= I_RTC_MIN;
			if (start) begin
				dfa_ff <= 1'b1;
				first_ff <= 1'b0;
			end else if (dfa_end) begin
				dfa_ff <= 1'b0;
			end
			if (dfa_end) begin
				elapsed_ff <= 16'h0000;
			end else if (min_tick_ff && count_en && (elapsed_ff != 16'hFFFF)) begin
				elapsed_ff <= elapsed_ff + 16'h0001;
			end
		end
	end

	assign O_AXI_AWREADY = awrdy_ff;
	assign O_AXI_WREADY = wrdy_ff;
	assign O_AXI_BVALID = bvalid_ff;
	assign O_AXI_BRESP = bresp_ff;
	assign O_AXI_ARREADY = arrdy_ff;
	assign O_AXI_RVALID = rvalid_ff;
	assign O_AXI_RDATA = rdata_ff;
	assign O_AXI_RRESP = rresp_ff;
	assign O_COMP = comp_ff;
	assign O_DEFROST = dfo_ff;
	assign O_AUX = aux_ff;
	assign O_PROP_DEFPWR = prop_ff;
	assign O_LAMP = lamp_ff;
	assign O_HOLDOFF_IND = hind_ff;
	assign O_DEFROST_ACT = dfa_ff;

	////////////////////////////////////////////////////////////////////////////////
	// Assertions.

	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (!rst_n);

	sequence s_req_rise;
		want && !demand_ff && (tp_ff[0] != 16'h0000);
	endsequence
	sequence s_held_off;
		busy[0] && !comp_ff ##1 !comp_ff;
	endsequence

	a_comp_guard:
	assert property ($rose(comp_ff) |-> $past(!prot_busy && !holdoff_act))
		else $error("Compressor turned on while a guard was running.");
	a_turnon_delay:
	assert property (s_req_rise |=> s_held_off)
		else $error("Turn-on delay did not hold the compressor off.");
	a_offon_start:
	assert property (comp_fall && !hg && (tp_ff[1] != 16'h0000) |=> busy[1])
		else $error("Off-to-on timer did not start at turn-off.");
	a_onon_start:
	assert property ($rose(comp_ff) && (tp_ff[2] != 16'h0000) |=> busy[2])
		else $error("On-to-on timer did not start at turn-on.");
	a_lamp_blink:
	assert property (want && !comp_ff && prot_busy |=> O_LAMP == $past(blink_ff))
		else $error("Lamp did not follow the blink phase while inhibited.");
	a_holdoff_quiet:
	assert property (holdoff_act |=> !O_COMP && !O_DEFROST && !O_AUX && !O_PROP_DEFPWR)
		else $error("An output was active during the hold-off.");
	a_electric_stop:
	assert property (dfa_ff && dtype == cgd_pkg::DT_EL |=>
		!O_COMP && (O_DEFROST == $past(ctrl_ff[cgd_pkg::CTRL_DFU] && !holdoff_act)))
		else $error("Electric defrost drove the wrong outputs.");
	a_et_noprobe:
	assert property (dfa_ff && dtype == cgd_pkg::DT_ET && !I_EVAP_OK && !holdoff_act |=> O_DEFROST)
		else $error("Defrost output dropped with the evaporator probe faulty.");
	a_hg_only_hot:
	assert property (dfa_ff && hg && !busy[1] && !holdoff_act |=> O_DEFROST && !O_COMP && !O_AUX)
		else $error("Hot-gas defrost drove a valve other than hot gas.");
	a_start_gate:
	assert property ($rose(dfa_ff) |-> $past(start_ok))
		else $error("Defrost started above the enable temperature.");
	a_ct_hold:
	assert property (dcnt == cgd_pkg::DC_CT && !comp_ff && !dfa_end |=> $stable(elapsed_ff))
		else $error("Interval advanced with the compressor off.");

endmodule // cgd_top

// ==== rtl/cgd_pkg.sv ====
// Package of constants, types and helpers for the compressor guard and defrost sequencer.
// Behaviour
// - Compressor output turns on only when all three protection timers have expired.
// - First timer delays each turn-on, counted from the cooling request.
// - Second timer starts at compressor turn-off and blocks reactivation until expired.
// - Third timer starts at each turn-on, spacing two successive turn-ons.
// - Output lamp blinks while a protection timer inhibits the compressor.
// - After power-up all outputs stay off for the hold-off; indication alternates. The lamp output is not gated by the hold-off.
// - A timer or hold-off whose setting is off applies no delay. The hold-off loads only at reset, so it always lasts POD_RST seconds.
// - Hot-gas mode reuses first and second times as valve delays.
// - Electric mode: compressor off, defrost output on if assigned.
// - Hot-gas inversion mode: compressor and defrost output both on, separate power.
// - Unconditioned mode: compressor keeps regulating, defrost output also on.
// - Thermostatted mode: defrost output heats to end temperature, 1 degree hysteresis.
// - Thermostatted mode with probe off or faulty keeps defrost output on.
// - Centralized hot-gas: only hot-gas valve active in defrost, timed valves around.
// - Automatic defrost starts inhibited while evaporator is above enable temperature.
// - Clock mode disables interval defrost, starts from fourteen timed events.
// - Day codes: one to seven days, eight daily, nine to eleven groups, off.
// - Total-time mode advances interval timer whenever powered.
// - Compressor-time mode advances interval timer only while compressor is on.
// - Stop mode defrosts at each compressor stop or at interval expiry.
// - Interval runs from defrost end to next start; off disables interval defrosts.
// - First defrost waits its own delay; off means defrost at each power-up.
package cgd_pkg;

	// Register byte addresses.
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_P1 = 8'h04;
	localparam logic [7:0] ADDR_P2 = 8'h08;
	localparam logic [7:0] ADDR_P3 = 8'h0C;
	localparam logic [7:0] ADDR_POD = 8'h10;
	localparam logic [7:0] ADDR_DI = 8'h14;
	localparam logic [7:0] ADDR_SD = 8'h18;
	localparam logic [7:0] ADDR_TEMP = 8'h1C;
	localparam logic [7:0] ADDR_STAT = 8'h20;
	localparam logic [1:0] EVT_PAGE = 2'h1;
	localparam int EVT_NUM = 14;

	// Control register fields.
	localparam int CTRL_DT_LSB = 0;
	localparam int CTRL_DT_MSB = 2;
	localparam int CTRL_DC_LSB = 3;
	localparam int CTRL_DC_MSB = 4;
	localparam int CTRL_DFU = 5;
	localparam int CTRL_W = 6;

	// Reset values.
	localparam logic [CTRL_W-1:0] CTRL_RST = 6'h20;
	localparam logic [15:0] TIME_RST = 16'h0000;
	localparam logic [15:0] POD_RST = 16'h0002;
	localparam logic [15:0] DI_RST = 16'h0000;
	localparam logic [15:0] SD_RST = 16'h0000;
	localparam logic [15:0] TEND_RST = 16'h0050;
	localparam logic [15:0] TENA_RST = 16'h0020;

	// Thermostat hysteresis of 1 degree in tenths of a degree.
	localparam logic signed [15:0] HYST = 16'sh000A;

	// Time base.
	localparam int CLK_HZ = 250000000;
	localparam int TICK_PERIOD_S = 1;
	localparam int TICK_CYC = CLK_HZ * TICK_PERIOD_S;
	localparam logic [5:0] SEC_PER_MIN = 6'h3C;

	// AXI responses.
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Day selector codes; days count 0 for Monday up to 6 for Sunday.
	localparam logic [3:0] DAY_OFF = 4'h0;
	localparam logic [3:0] DAY_MON = 4'h1;
	localparam logic [3:0] DAY_SUN = 4'h7;
	localparam logic [3:0] DAY_EVERY = 4'h8;
	localparam logic [3:0] DAY_WEEK = 4'h9;
	localparam logic [3:0] DAY_MONSAT = 4'hA;
	localparam logic [3:0] DAY_WEEKEND = 4'hB;
	localparam logic [2:0] DAY_FRI = 3'h4;
	localparam logic [2:0] DAY_SAT = 3'h5;

	typedef enum logic [2:0] {DT_EL, DT_IN, DT_NO, DT_ET, DT_HG} cgd_dtype_t;
	typedef enum logic [1:0] {DC_RT, DC_CT, DC_CS, DC_CL} cgd_dcnt_t;

	// Tells whether a day selector code covers the given weekday.
	function automatic logic day_match(input logic [3:0] code, input logic [2:0] day);
		case (code)
			DAY_OFF: day_match = 1'b0;
			DAY_EVERY: day_match = 1'b1;
			DAY_WEEK: day_match = (day <= DAY_FRI);
			DAY_MONSAT: day_match = (day <= DAY_SAT);
			DAY_WEEKEND: day_match = (day >= DAY_SAT);
			default: day_match = (code >= DAY_MON) && (code <= DAY_SUN) &&
				({1'b0, day} == code - DAY_MON);
		endcase
	endfunction

endpackage

// ==== rtl/cgd_countdown.sv ====
// Seconds countdown timer used for protection and hold-off delays.
`timescale 1ns/1ps
module cgd_countdown #(
	parameter int W = 16
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_tick,
	input wire logic i_load,
	input wire logic [W-1:0] i_value,
	output logic o_busy
);

	logic [W-1:0] cnt_ff;

	// A load wins over a tick; a zero load means the delay is off.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt_ff <= '0;
		end else if (i_load) begin
			cnt_ff <= i_value;
		end else if (i_tick && (cnt_ff != '0)) begin
			cnt_ff <= cnt_ff - W'(1);
		end
	end

	// Busy while any whole second is left.
	assign o_busy = (cnt_ff != '0);

endmodule // cgd_countdown

// ==== tb/cgd_act_model.sv ====
// Actuator and evaporator model facing the sequencer outputs.
`timescale 1ns/1ps
module cgd_act_model (
	input wire logic i_defrost,
	input wire logic i_warm,
	input wire logic i_fail,
	output logic signed [15:0] o_evap_temp,
	output logic o_evap_ok
);
	// Heater or hot gas warms the evaporator to 4.0 C, otherwise it sits at 0 C.
	assign o_evap_temp = (i_defrost || i_warm) ? 16'sh0028 : 16'sh0000;
	// A failed probe reports itself as not healthy.
	assign o_evap_ok = !i_fail;
endmodule // cgd_act_model

// ==== tb/cgd_top_tb.sv ====
// Self-checking bench for the compressor guard and defrost sequencer.
`timescale 1ns/1ps
module cgd_top_tb;
	logic clk = 1'b0, nrst = 1'b0, awv = 1'b0, wv = 1'b0, bready = 1'b0;
	logic arv = 1'b0, rready = 1'b0, req = 1'b1, dend = 1'b0, warm = 1'b0;
	logic pfail = 1'b0, hoi_seen = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, rd_d;
	logic [1:0] bresp, rresp, b_r, r_r;
	logic awready, wready, bvalid, arready, rvalid, comp, dfo, aux, ppw, lamp, hoi, act, eok;
	logic signed [15:0] temp;
	int mismatches = 0, total_checks = 0, n, t;
	cgd_top #(.TICK_CYCLES(8)) uut (.I_CLK(clk), .I_NRST(nrst), .I_AXI_AWADDR(awaddr),
		.I_AXI_AWVALID(awv), .O_AXI_AWREADY(awready), .I_AXI_WDATA(wdata),
		.I_AXI_WSTRB(4'hF), .I_AXI_WVALID(wv), .O_AXI_WREADY(wready), .O_AXI_BRESP(bresp),
		.O_AXI_BVALID(bvalid), .I_AXI_BREADY(bready), .I_AXI_ARADDR(araddr),
		.I_AXI_ARVALID(arv), .O_AXI_ARREADY(arready), .O_AXI_RDATA(rdata),
		.O_AXI_RRESP(rresp), .O_AXI_RVALID(rvalid), .I_AXI_RREADY(rready),
		.I_COOL_REQ(req), .I_EVAP_TEMP(temp), .I_EVAP_OK(eok), .I_DEFROST_END(dend),
		.I_RTC_DAY(3'h0), .I_RTC_MIN(11'h000), .O_COMP(comp), .O_DEFROST(dfo), .O_AUX(aux),
		.O_PROP_DEFPWR(ppw), .O_LAMP(lamp), .O_HOLDOFF_IND(hoi), .O_DEFROST_ACT(act));
	cgd_act_model model (.i_defrost(dfo), .i_warm(warm), .i_fail(pfail), .o_evap_temp(temp),
		.o_evap_ok(eok));
	// Free-running 250 MHz clock.
	always #2 clk = ~clk;
	// Remembers that the hold-off indication was shown at least once.
	always @(posedge clk) begin
		if (hoi === 1'b1) begin
			hoi_seen <= 1'b1;
		end
	end
	////////////////////////////////////////////////////////////////////////////////////////
	// Prints the counts and the verdict, then stops the run.
	task automatic end_sim();
		$display("Checks %0d, mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// Compares one value and reports a difference at once.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %0t %s", $time, m);
		end
	endtask
	// A wait that used up its bound ends the run.
	task automatic hang(input int k);
		if (k >= 60) begin
			mismatches++;
			$display("MISMATCH %0t bus hang", $time);
			end_sim();
		end
	endtask
	// AXI4-Lite write: address and data offered together, each held until taken.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		bready <= 1'b1;
		for (k = 0; k < 60; k++) begin
			@(posedge clk);
			if (awready === 1'b1) awv <= 1'b0;
			if (wready === 1'b1) wv <= 1'b0;
			if (bvalid === 1'b1) break;
		end
		b_r = bresp;
		bready <= 1'b0;
		hang(k);
	endtask
	// AXI4-Lite read: address held until taken, data taken at the rvalid edge.
	task automatic rd(input logic [7:0] a);
		int k;
		@(posedge clk);
		araddr <= a;
		arv <= 1'b1;
		rready <= 1'b1;
		for (k = 0; k < 60; k++) begin
			@(posedge clk);
			if (arready === 1'b1) arv <= 1'b0;
			if (rvalid === 1'b1) break;
		end
		rd_d = rdata;
		r_r = rresp;
		rready <= 1'b0;
		hang(k);
	endtask
	////////////////////////////////////////////////////////////////////////////////////////
	// Main sequence of tests.
	initial begin
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		repeat (4) @(posedge clk);
		chk(comp, 1'b0, "comp during hold-off");
		rd(cgd_pkg::ADDR_CTRL);
		chk(rd_d, 32'h20, "ctrl reset");
		rd(cgd_pkg::ADDR_POD);
		chk(rd_d, 32'h2, "hold-off reset");
		rd(cgd_pkg::ADDR_TEMP);
		chk(rd_d, 32'h00200050, "temp reset");
		rd(8'h3C);
		chk(rd_d, 32'h0, "unmapped read data");
		chk(r_r, cgd_pkg::RESP_SLVERR, "unmapped read response");
		repeat (30) @(posedge clk);
		chk(comp, 1'b1, "comp after hold-off");
		chk(hoi_seen, 1'b1, "hold-off indication shown");
		chk(hoi, 1'b0, "hold-off indication cleared");
		chk(act, 1'b0, "no defrost with interval off");
		$display("Test hold-off done");
		wr(cgd_pkg::ADDR_STAT, 32'hFF);
		chk(b_r, cgd_pkg::RESP_SLVERR, "status write");
		wr(cgd_pkg::ADDR_P1, 32'h3);
		req <= 1'b0;
		repeat (3) @(posedge clk);
		req <= 1'b1;
		repeat (5) @(posedge clk);
		chk(comp, 1'b0, "turn-on delay");
		// The lamp must show both phases over ten cycles of the delay.
		n = 0;
		repeat (10) begin
			@(posedge clk);
			n += lamp;
		end
		chk(n > 0 && n < 10, 1'b1, "lamp blink while held off");
		repeat (15) @(posedge clk);
		chk(comp, 1'b1, "comp after delay");
		wr(cgd_pkg::ADDR_P1, 32'h0);
		req <= 1'b0;
		repeat (3) @(posedge clk);
		req <= 1'b1;
		repeat (4) @(posedge clk);
		chk(comp, 1'b1, "no delay when off");
		$display("Test guards done");
		// Defrost at compressor stop for every type; the probe is failed in the thermostatted one.
		for (t = 0; t < 5; t++) begin
			wr(cgd_pkg::ADDR_CTRL, 32'h30 | t);
			req <= 1'b1;
			pfail <= (t == 3);
			repeat (6) @(posedge clk);
			req <= 1'b0;
			repeat (6) @(posedge clk);
			chk(act, 1'b1, "defrost at stop");
			chk({comp, dfo}, {t == 1, 1'b1}, "defrost outputs");
			chk(ppw, t == 1, "defrost power");
			chk(aux, 1'b0, "suction valve in defrost");
			@(posedge clk);
			// Cooling is requested again so the end of defrost is no compressor stop.
			dend <= 1'b1;
			req <= 1'b1;
			@(posedge clk);
			dend <= 1'b0;
			pfail <= 1'b0;
			repeat (3) @(posedge clk);
			chk(act, 1'b0, "defrost end");
			chk(aux, t == 4, "suction valve outside defrost");
		end
		warm <= 1'b1;
		req <= 1'b1;
		repeat (6) @(posedge clk);
		req <= 1'b0;
		repeat (6) @(posedge clk);
		chk(act, 1'b0, "warm evaporator start");
		$display("Test defrost done");
		// Compressor-time counting: the interval stands while off and grows while on.
		wr(cgd_pkg::ADDR_CTRL, 32'h28);
		rd(cgd_pkg::ADDR_STAT);
		n = rd_d[31:16];
		repeat (600) @(posedge clk);
		rd(cgd_pkg::ADDR_STAT);
		chk(rd_d[31:16], n, "interval held with compressor off");
		req <= 1'b1;
		repeat (600) @(posedge clk);
		rd(cgd_pkg::ADDR_STAT);
		chk(rd_d[31:16] > n, 1'b1, "interval counts compressor time");
		$display("Test interval done");
		end_sim();
	end
endmodule // cgd_top_tb
